// ### include/pwm_pkg.sv
// constants, field layouts and carriers for the six-bit pulse width modulator
// assumes one oscillator-rate clock and a byte-wide register port
package pwm_pkg;

  // register offsets on the byte port
  localparam logic [7:0] DUTY_OFFSET = 8'h30;
  localparam logic [7:0] CTRL_OFFSET = 8'h31;

  // counter and field widths
  localparam int COUNT_WIDTH = 6;
  localparam int PSB_WIDTH   = 4;

  // duty register bit positions
  localparam int DUTY_POL_BIT = 7;

  // control register field positions
  localparam int CTRL_PSA_HI_BIT = 5;
  localparam int CTRL_PSA_LO_BIT = 4;
  localparam int CTRL_PSB_MSB    = 3;

  // reset values
  localparam logic       POL_RESET = 1'b1;
  localparam logic [1:0] PSA_RESET = 2'h0;
  localparam logic [3:0] PSB_RESET = 4'h0;

  // prescaler a select codes
  localparam logic [1:0] PSA_OFF   = 2'h0;
  localparam logic [1:0] PSA_DIV1  = 2'h1;
  localparam logic [1:0] PSA_DIV8  = 2'h2;
  localparam logic [1:0] PSA_DIV16 = 2'h3;

  // prescaler a terminal counts (divide minus one)
  localparam logic [3:0] PSA_LAST_DIV1  = 4'h0;
  localparam logic [3:0] PSA_LAST_DIV8  = 4'h7;
  localparam logic [3:0] PSA_LAST_DIV16 = 4'hf;

  // last step of the modulus counter
  localparam logic [5:0] COUNT_LAST = 6'h3f;

  typedef struct packed {
    logic       prescale_a_sel_hi;
    logic       prescale_a_sel_lo;
    logic [3:0] prescale_b_sel;
  } clock_sel_type;

  typedef struct packed {
    logic       output_polarity;
    logic [5:0] duty;
  } duty_type;

endpackage : pwm_pkg

// ### rtl/six_bit_pwm_channel.sv
// six-bit pulse width modulator channel with buffered duty register
// assumes clock_i is the oscillator clock and bus strobes are one cycle long
//
// Behaviour
// - one channel, 64-step free-running modulus counter
// - duty zero gives 0%, 63 gives 63/64
// - polarity low with duty zero gives constant high
// - prescaler a code 00 switches everything off
// - enabled duty writes wait in buffer until period end
// - enabled control writes act on next clock
// - disabled writes go straight to active registers
// - pending contents applied together at period end
// - duty read returns active register, not buffer
// - top duty bit selects polarity, reset sets it
// - duty in low six bits, reset leaves it
// - prescaler a divides by 1, 8 or 16
// - prescaler b divides by 1 to 16
// - keeps running while processor waits
// - halted oscillator freezes channel mid-pulse
// - reset clears prescaler a, output low
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module six_bit_pwm_channel
(
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  // oscillator halted in stop state
  input  wire logic       stop_i,
  // register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // modulated output
  output logic            modulator_channel_a_o
);

  pwm_pkg::clock_sel_type ctrl_reg;
  pwm_pkg::clock_sel_type ctrl_next;
  logic                   pol_reg;
  logic                   pol_next;
  logic                   pol_buf_reg;
  logic                   pol_buf_next;
  logic [5:0]             duty_reg;
  logic [5:0]             duty_next;
  logic [5:0]             duty_buf_reg;
  logic [5:0]             duty_buf_next;
  logic                   pend_reg;
  logic                   pend_next;
  logic [3:0]             a_cnt_reg;
  logic [3:0]             a_cnt_next;
  logic [3:0]             b_cnt_reg;
  logic [3:0]             b_cnt_next;
  logic [5:0]             cnt_reg;
  logic [5:0]             cnt_next;
  logic                   out_reg;
  logic                   out_next;
  logic [7:0]             rdata_reg;
  logic [7:0]             rdata_next;

  logic       enabled;
  logic       run;
  logic [3:0] a_last;
  logic       a_tick;
  logic       b_tick;
  logic       period_end;
  logic       wr_duty;
  logic       wr_ctrl;

  assign wr_duty = wr_i && (addr_i == pwm_pkg::DUTY_OFFSET);
  assign wr_ctrl = wr_i && (addr_i == pwm_pkg::CTRL_OFFSET);
  assign enabled = {ctrl_reg.prescale_a_sel_hi, ctrl_reg.prescale_a_sel_lo} != pwm_pkg::PSA_OFF;
  // no wait input: the channel ignores the processor wait state
  assign run     = enabled && !stop_i;

  always_comb
  begin
    unique case ({ctrl_reg.prescale_a_sel_hi, ctrl_reg.prescale_a_sel_lo})
      pwm_pkg::PSA_DIV8:  a_last = pwm_pkg::PSA_LAST_DIV8;
      pwm_pkg::PSA_DIV16: a_last = pwm_pkg::PSA_LAST_DIV16;
      default:            a_last = pwm_pkg::PSA_LAST_DIV1;
    endcase
  end

  assign a_tick     = run && (a_cnt_reg == a_last);
  assign b_tick     = a_tick && (b_cnt_reg == ctrl_reg.prescale_b_sel);
  assign period_end = b_tick && (cnt_reg == pwm_pkg::COUNT_LAST);

  // prescalers, modulus counter and output
  always_comb
  begin
    a_cnt_next = a_cnt_reg;
    b_cnt_next = b_cnt_reg;
    cnt_next   = cnt_reg;
    out_next   = out_reg;
    if (!enabled)
    begin
      a_cnt_next = 4'h0;
      b_cnt_next = 4'h0;
      cnt_next   = 6'h00;
      out_next   = 1'b0;
    end
    else if (!stop_i)
    begin
      a_cnt_next = a_tick ? 4'h0 : a_cnt_reg + 4'h1;
      if (a_tick)
        b_cnt_next = b_tick ? 4'h0 : b_cnt_reg + 4'h1;
      if (b_tick)
        cnt_next = cnt_reg + 6'h01;
      // active below duty, polarity picks level
      out_next = pol_reg ? (cnt_reg < duty_reg) : !(cnt_reg < duty_reg);
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      a_cnt_reg <= 4'h0;
      b_cnt_reg <= 4'h0;
      cnt_reg   <= 6'h00;
      out_reg   <= 1'b0;
    end
    else
    begin
      a_cnt_reg <= a_cnt_next;
      b_cnt_reg <= b_cnt_next;
      cnt_reg   <= cnt_next;
      out_reg   <= out_next;
    end
  end

  // register file and duty buffer
  always_comb
  begin
    ctrl_next     = ctrl_reg;
    pol_next      = pol_reg;
    pol_buf_next  = pol_buf_reg;
    duty_next     = duty_reg;
    duty_buf_next = duty_buf_reg;
    pend_next     = pend_reg;
    rdata_next    = 8'h00;
    if (wr_ctrl)
      ctrl_next = wdata_i[pwm_pkg::CTRL_PSA_HI_BIT:0];
    if (!enabled)
    begin
      pend_next = 1'b0;
      if (wr_duty)
      begin
        pol_next  = wdata_i[pwm_pkg::DUTY_POL_BIT];
        duty_next = wdata_i[5:0];
      end
    end
    else
    begin
      if (period_end && pend_reg)
      begin
        pol_next  = pol_buf_reg;
        duty_next = duty_buf_reg;
        pend_next = 1'b0;
      end
      // a write in the load cycle stays pending for the next period
      if (wr_duty)
      begin
        pol_buf_next  = wdata_i[pwm_pkg::DUTY_POL_BIT];
        duty_buf_next = wdata_i[5:0];
        pend_next     = 1'b1;
      end
    end
    if (rd_i)
    begin
      if (addr_i == pwm_pkg::DUTY_OFFSET)
        rdata_next = {pol_reg, 1'b0, duty_reg};
      else if (addr_i == pwm_pkg::CTRL_OFFSET)
        rdata_next = {2'h0, ctrl_reg};
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_reg    <= {pwm_pkg::PSA_RESET, pwm_pkg::PSB_RESET};
      pol_reg     <= pwm_pkg::POL_RESET;
      pol_buf_reg <= pwm_pkg::POL_RESET;
      pend_reg    <= 1'b0;
      rdata_reg   <= 8'h00;
    end
    else
    begin
      ctrl_reg    <= ctrl_next;
      pol_reg     <= pol_next;
      pol_buf_reg <= pol_buf_next;
      pend_reg    <= pend_next;
      rdata_reg   <= rdata_next;
    end
  end

  // duty bits keep their value through reset
  always_ff @(posedge clock_i)
  begin
    duty_reg     <= duty_next;
    duty_buf_reg <= duty_buf_next;
  end

  // helper: running clocks between counter steps, for the divider check
  logic [8:0] step_len_reg;
  logic [8:0] step_len_next;
  logic       step_ok_reg;
  logic       step_ok_next;
  logic [8:0] step_div;
  logic [8:0] step_exp;

  always_comb
  begin
    step_len_next = step_len_reg;
    step_ok_next  = step_ok_reg;
    unique case ({ctrl_reg.prescale_a_sel_hi, ctrl_reg.prescale_a_sel_lo})
      pwm_pkg::PSA_DIV8:  step_div = 9'h008;
      pwm_pkg::PSA_DIV16: step_div = 9'h010;
      default:            step_div = 9'h001;
    endcase
    step_exp = step_div * ({5'h00, ctrl_reg.prescale_b_sel} + 9'h001) - 9'h001;
    // a new setting leaves one partial step, so wait for a full one
    if (!enabled || wr_ctrl)
    begin
      step_len_next = 9'h000;
      step_ok_next  = 1'b0;
    end
    else if (b_tick)
    begin
      step_len_next = 9'h000;
      step_ok_next  = 1'b1;
    end
    else if (run)
      step_len_next = step_len_reg + 9'h001;
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      step_len_reg <= 9'h000;
      step_ok_reg  <= 1'b0;
    end
    else
    begin
      step_len_reg <= step_len_next;
      step_ok_reg  <= step_ok_next;
    end
  end

  assign rdata_o               = rdata_reg;
  assign modulator_channel_a_o = out_reg;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);

  a_off_low: assert property (!enabled |=> !modulator_channel_a_o)
    else $error("output not low while disabled");
  a_off_count: assert property (!enabled |=> cnt_reg == 6'h00 && a_cnt_reg == 4'h0)
    else $error("counters run while disabled");
  a_zero_low: assert property (run && pol_reg && duty_reg == 6'h00 |=> !modulator_channel_a_o)
    else $error("zero duty not low");
  a_zero_full: assert property (run && !pol_reg && duty_reg == 6'h00 |=> modulator_channel_a_o)
    else $error("inverted zero duty not high");
  a_compare_level: assert property (run ##1 enabled |-> modulator_channel_a_o ==
    ($past(pol_reg) ~^ ($past(cnt_reg) < $past(duty_reg))))
    else $error("output level does not follow compare");
  a_buffer_hold: assert property (enabled && wr_duty && !period_end |=> duty_reg == $past(duty_reg))
    else $error("buffered duty took effect early");
  a_period_load: assert property (period_end && pend_reg && !wr_ctrl |=>
    duty_reg == $past(duty_buf_reg) && pol_reg == $past(pol_buf_reg))
    else $error("pending duty not loaded at period end");
  a_ctrl_now: assert property (wr_ctrl |=> ctrl_reg == $past(wdata_i[5:0]))
    else $error("control write not immediate");
  a_direct_load: assert property (!enabled && wr_duty |=> duty_reg == $past(wdata_i[5:0]))
    else $error("disabled duty write not direct");
  a_read_active: assert property (rd_i && addr_i == pwm_pkg::DUTY_OFFSET |=>
    rdata_o == {$past(pol_reg), 1'b0, $past(duty_reg)})
    else $error("duty read not from active register");
  a_stop_freeze: assert property (enabled && stop_i && !wr_ctrl |=>
    cnt_reg == $past(cnt_reg) && modulator_channel_a_o == $past(modulator_channel_a_o))
    else $error("channel moved while stopped");
  a_div8_step: assert property (b_tick && {ctrl_reg.prescale_a_sel_hi, ctrl_reg.prescale_a_sel_lo} ==
    pwm_pkg::PSA_DIV8 && ctrl_reg.prescale_b_sel == 4'h0 && !stop_i && !wr_ctrl ##1
    (!stop_i && !wr_ctrl)[*7] |=> b_tick)
    else $error("prescaler a divide by eight wrong");
  a_step_length: assert property (b_tick && step_ok_reg |-> step_len_reg == step_exp)
    else $error("counter step length does not match prescalers");
  a_off_forget: assert property (!enabled |=> !pend_reg)
    else $error("pending write kept while disabled");
  a_wrap_zero: assert property (period_end && !wr_ctrl |=> cnt_reg == 6'h00)
    else $error("counter did not wrap");

  c_period_load: cover property (period_end && pend_reg);
  c_inverted_run: cover property (run && !pol_reg ##1 modulator_channel_a_o);
  c_stop_midpulse: cover property (run && modulator_channel_a_o ##1 stop_i);
  c_direct_write: cover property (!enabled && wr_duty);
  c_div16_step: cover property (b_tick && step_ok_reg && step_div == 9'h010);

endmodule : six_bit_pwm_channel
`default_nettype wire

// ### testbench/pwm_load_model.sv
// load on the modulated pin: counts clocks the pin is high
// assumes en_i is held by the bench for the whole window
`timescale 1ns/10ps
`default_nettype none
module pwm_load_model
(
  // clock
  input  wire logic        clock_i,
  // window enable and observed pin
  input  wire logic        en_i,
  input  wire logic        pin_i,
  // high time seen in the window
  output var  logic [15:0] high_cnt_o
);
  always_ff @(posedge clock_i)
  begin
    if (!en_i)
      high_cnt_o <= 16'h0000;
    else if (pin_i === 1'b1)
      high_cnt_o <= high_cnt_o + 16'h0001;
  end
endmodule : pwm_load_model
`default_nettype wire

// ### testbench/six_bit_pwm_channel_tb_top.sv
// self-checking bench for the six-bit modulator channel
// assumes the register port and control layout of pwm_pkg
`timescale 1ns/10ps
`default_nettype none
module six_bit_pwm_channel_tb_top;
  typedef struct {logic [7:0] duty; logic [7:0] ctrl; int len; logic [15:0] high;} row_type;
  logic clock_i = 1'b0, arst_n_i = 1'b0, stop_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, en = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, rd_val;
  logic modulator_channel_a_o, held;
  logic [15:0] high_cnt;
  int err_total = 0, n_compared = 0, cycles = 0;
  localparam logic [7:0] DA = pwm_pkg::DUTY_OFFSET;
  localparam logic [7:0] CA = pwm_pkg::CTRL_OFFSET;
  row_type rows [6] = '{
    '{8'h80, 8'h10, 64, 16'h0000},   // zero duty, high polarity
    '{8'hbf, 8'h10, 64, 16'h003f},   // full duty 63 of 64
    '{8'h00, 8'h10, 64, 16'h0040},   // low polarity, zero duty
    '{8'h85, 8'h20, 512, 16'h0028},  // divide by 8
    '{8'h0a, 8'h30, 1024, 16'h0360}, // divide by 16, low polarity
    '{8'h83, 8'h1f, 1024, 16'h0030}  // prescaler b at 16
  };

  six_bit_pwm_channel u_dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .stop_i(stop_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .modulator_channel_a_o(modulator_channel_a_o));
  pwm_load_model u_load (.clock_i(clock_i), .en_i(en), .pin_i(modulator_channel_a_o), .high_cnt_o(high_cnt));

  initial
  begin
    forever #20 clock_i = ~clock_i;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 rd_val = rdata_o;
  endtask : rd

  // settle, then count high clocks over one whole period
  task automatic measure(input int len, input logic [15:0] exp, input string name);
    repeat (4) @(posedge clock_i);
    en <= 1'b1;
    repeat (len) @(posedge clock_i);
    en <= 1'b0;
    #1 chk(name, exp, high_cnt);
    $display("test %s done", name);
  endtask : measure

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      final_report();
    end
  end

  initial
  begin
    repeat (6) @(posedge clock_i);
    arst_n_i <= 1'b1;
    foreach (rows[i])
    begin
      wr(DA, rows[i].duty);
      wr(CA, rows[i].ctrl);
      measure(rows[i].len, rows[i].high, "period");
      wr(CA, 8'h00);
      repeat (3) @(posedge clock_i);
      chk("off_out", 16'h0000, {15'h0000, modulator_channel_a_o});
    end
    wr(DA, 8'h8a);
    wr(CA, 8'h10);
    wr(DA, 8'ha8);
    rd(DA);
    chk("duty_pending", 16'h008a, {8'h00, rd_val});
    repeat (70) @(posedge clock_i);
    rd(DA);
    chk("duty_loaded", 16'h00a8, {8'h00, rd_val});
    measure(64, 16'h0028, "buffered");
    wr(CA, 8'h20);
    measure(512, 16'h0140, "ctrl_now");
    @(posedge clock_i);
    stop_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    en <= 1'b1;
    #1 held = modulator_channel_a_o;
    repeat (100) @(posedge clock_i);
    en <= 1'b0;
    #1 chk("stop_hold", {15'h0000, held}, {15'h0000, modulator_channel_a_o});
    chk("stop_count", held ? 16'h0064 : 16'h0000, high_cnt);
    @(posedge clock_i);
    stop_i <= 1'b0;
    $display("test stop done");
    wr(CA, 8'h00);
    wr(8'h32, 8'hff);
    rd(8'h32);
    chk("unmapped", 16'h0000, {8'h00, rd_val});
    wr(DA, 8'h7f);
    rd(DA);
    chk("duty_direct", 16'h003f, {8'h00, rd_val});
    @(posedge clock_i);
    arst_n_i <= 1'b0;
    #1 chk("reset_out", 16'h0000, {15'h0000, modulator_channel_a_o});
    repeat (2) @(posedge clock_i);
    arst_n_i <= 1'b1;
    rd(CA);
    chk("reset_ctrl", 16'h0000, {8'h00, rd_val});
    rd(DA);
    chk("reset_duty", 16'h00bf, {8'h00, rd_val});
    $display("test registers done");
    final_report();
  end
endmodule : six_bit_pwm_channel_tb_top
`default_nettype wire
